/* File: core/multiplier_operation_control.sv */
// APB register block that triggers multiply operations from operand writes
// Operation
// - Accumulator is high, middle and low words joined into one running result.
// - Two-operand mode without square starts only after both operands are written.
// - One-operand mode without square starts on any single operand write.
// - Operand count select is ignored while square mode is on.
// - Operand count and square settings do not touch division behaviour.
// - Square mode starts a square right after one operand write.
// - Square mode writes the same value into both operands.
// - With square off, no mirroring; operand count rule applies.
// - Accumulate select and subtract select choose the operation; result goes to accumulator.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module multiplier_operation_control
    import mult_ctrl_pkg::*;
#(
    parameter int OPW   = OP_W,
    parameter int ADDRW = ADDR_W
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDRW-1:0]  paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr
);

    localparam int ACCW = 3 * OPW;

    // Bus state
    bus_state_t          bus_state;
    bus_state_t          next_bus_state;
    logic [DATA_W-1:0]   next_prdata;
    logic                next_pready;
    logic                next_pslverr;

    // Datapath state
    multiplier_control_t control;
    multiplier_control_t next_control;
    logic [OPW-1:0]      operand_a;
    logic [OPW-1:0]      operand_b;
    logic [OPW-1:0]      next_operand_a;
    logic [OPW-1:0]      next_operand_b;
    logic [OPW-1:0]      accumulator_low;
    logic [OPW-1:0]      accumulator_mid;
    logic [OPW-1:0]      accumulator_high;
    logic [OPW-1:0]      next_accumulator_low;
    logic [OPW-1:0]      next_accumulator_mid;
    logic [OPW-1:0]      next_accumulator_high;
    logic                written_a;
    logic                written_b;
    logic                next_written_a;
    logic                next_written_b;
    logic                op_pending;
    logic                next_op_pending;

    // Decode
    logic [IDX_W-1:0]    reg_index;
    logic                aligned;
    logic                hit_control;
    logic                hit_a;
    logic                hit_b;
    logic                hit_low;
    logic                hit_mid;
    logic                hit_high;
    logic                hit_status;
    logic                mapped;
    logic                access_done;
    logic                write_done;
    logic                operand_write;
    logic [ACCW-1:0]     accumulator;
    logic [ACCW-1:0]     mac_result;
    logic [OPW-1:0]      write_word;
    logic                start_op;
    logic [DATA_W-1:0]   read_word;

    assign accumulator = {accumulator_high, accumulator_mid, accumulator_low};
    assign write_word  = pwdata[OPW-1:0];
    assign reg_index   = paddr[ADDRW-1:2];
    assign aligned     = (paddr[1:0] == 2'h0);
    assign mapped      = hit_control || hit_a || hit_b || hit_low || hit_mid
                         || hit_high || hit_status;

    // Misaligned addresses match no register and so earn an error
    always_comb begin
        hit_control = 1'b0;
        hit_a       = 1'b0;
        hit_b       = 1'b0;
        hit_low     = 1'b0;
        hit_mid     = 1'b0;
        hit_high    = 1'b0;
        hit_status  = 1'b0;
        if (aligned) begin
            case (reg_index)
                MULTIPLIER_CONTROL_IDX: hit_control = 1'b1;
                OPERAND_A_IDX:          hit_a       = 1'b1;
                OPERAND_B_IDX:          hit_b       = 1'b1;
                ACCUMULATOR_LOW_IDX:    hit_low     = 1'b1;
                ACCUMULATOR_MID_IDX:    hit_mid     = 1'b1;
                ACCUMULATOR_HIGH_IDX:   hit_high    = 1'b1;
                OPERATION_STATUS_IDX:   hit_status  = 1'b1;
                default:                hit_status  = 1'b0;
            endcase
        end
    end

    // The write acts only at the edge that completes the access
    assign access_done   = psel && penable && pready;
    assign write_done    = access_done && pwrite && mapped;
    // Either operand register; the trigger and the load both key off this
    assign operand_write = write_done && (hit_a || hit_b);

    mac_unit #(
        .OPW  (OPW),
        .ACCW (ACCW)
    ) u_mac (
        .operand_a   (operand_a),
        .operand_b   (operand_b),
        .accumulator (accumulator),
        .control     (control),
        .result      (mac_result)
    );

    // Read mux; reserved and unmapped bits read as zero
    always_comb begin
        read_word = DATA_ZERO;
        if (hit_control) begin
            read_word[SIGN_MODE_BIT]     = control.unsigned_mode;
            read_word[ACCUMULATE_BIT]    = control.accumulate_select;
            read_word[SUBTRACT_BIT]      = control.subtract_select;
            read_word[OPERAND_COUNT_BIT] = control.operand_count_select;
            read_word[SQUARE_BIT]        = control.square_enable;
        end else if (hit_a) begin
            read_word[OPW-1:0] = operand_a;
        end else if (hit_b) begin
            read_word[OPW-1:0] = operand_b;
        end else if (hit_low) begin
            read_word[OPW-1:0] = accumulator_low;
        end else if (hit_mid) begin
            read_word[OPW-1:0] = accumulator_mid;
        end else if (hit_high) begin
            read_word[OPW-1:0] = accumulator_high;
        end else if (hit_status) begin
            read_word[WRITTEN_A_BIT] = written_a;
            read_word[WRITTEN_B_BIT] = written_b;
            read_word[PENDING_BIT]   = op_pending;
        end
    end

    // Bus group: one wait state, answer in the second access cycle
    always_comb begin
        next_bus_state = bus_state;
        next_prdata    = prdata;
        next_pready    = 1'b0;
        next_pslverr   = 1'b0;
        case (bus_state)
            BUS_IDLE: begin
                if (psel && penable) begin
                    next_bus_state = BUS_ANSWER;
                    next_pready    = 1'b1;
                    next_pslverr   = !mapped;
                    next_prdata    = (pwrite || !mapped) ? DATA_ZERO : read_word;
                end
            end
            BUS_ANSWER: begin
                next_bus_state = BUS_IDLE;
                next_prdata    = DATA_ZERO;
            end
            default: begin
                next_bus_state = BUS_IDLE;
                next_prdata    = DATA_ZERO;
            end
        endcase
    end

    // Registered answer keeps every bus output straight from a flip-flop
    always_ff @(posedge clock) begin
        if (rst) begin
            bus_state <= BUS_IDLE;
            prdata    <= DATA_ZERO;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
        end else begin
            bus_state <= next_bus_state;
            prdata    <= next_prdata;
            pready    <= next_pready;
            pslverr   <= next_pslverr;
        end
    end

    // Start decision for the operand write in this cycle
    always_comb begin
        start_op = 1'b0;
        if (operand_write) begin
            if (control.square_enable) begin
                start_op = 1'b1;
            end else if (control.operand_count_select) begin
                start_op = 1'b1;
            end else begin
                // Counts the write under way together with the earlier one
                start_op = (written_a || hit_a) && (written_b || hit_b);
            end
        end
    end

    // Datapath group
    always_comb begin
        next_control          = control;
        next_operand_a        = operand_a;
        next_operand_b        = operand_b;
        next_accumulator_low  = accumulator_low;
        next_accumulator_mid  = accumulator_mid;
        next_accumulator_high = accumulator_high;
        next_written_a        = written_a;
        next_written_b        = written_b;
        next_op_pending       = start_op;

        // Result lands one cycle after the starting write
        if (op_pending) begin
            {next_accumulator_high, next_accumulator_mid, next_accumulator_low} = mac_result;
        end

        // Bits above the square enable are dropped and read back as zero
        if (write_done && hit_control) begin
            next_control.unsigned_mode        = pwdata[SIGN_MODE_BIT];
            next_control.accumulate_select    = pwdata[ACCUMULATE_BIT];
            next_control.subtract_select      = pwdata[SUBTRACT_BIT];
            next_control.operand_count_select = pwdata[OPERAND_COUNT_BIT];
            next_control.square_enable        = pwdata[SQUARE_BIT];
        end

        if (operand_write) begin
            if (control.square_enable) begin
                next_operand_a = write_word;
                next_operand_b = write_word;
                // Pairing state is meaningless in square mode
                next_written_a = 1'b0;
                next_written_b = 1'b0;
            end else begin
                if (hit_a) begin
                    next_operand_a = write_word;
                end
                if (hit_b) begin
                    next_operand_b = write_word;
                end
                // One-operand mode keeps no pairing record
                if (control.operand_count_select) begin
                    next_written_a = 1'b0;
                    next_written_b = 1'b0;
                end else if (start_op) begin
                    next_written_a = 1'b0;
                    next_written_b = 1'b0;
                end else begin
                    next_written_a = written_a || hit_a;
                    next_written_b = written_b || hit_b;
                end
            end
        end

        // Software write to an accumulator word; cannot collide with a result
        // because writes are at least three cycles apart
        if (write_done && hit_low) begin
            next_accumulator_low = write_word;
        end
        if (write_done && hit_mid) begin
            next_accumulator_mid = write_word;
        end
        if (write_done && hit_high) begin
            next_accumulator_high = write_word;
        end
    end

    // No division path here, so mode bits act on multiplication only
    always_ff @(posedge clock) begin
        if (rst) begin
            control          <= CONTROL_RESET;
            operand_a        <= OPERAND_RESET;
            operand_b        <= OPERAND_RESET;
            accumulator_low  <= OPERAND_RESET;
            accumulator_mid  <= OPERAND_RESET;
            accumulator_high <= OPERAND_RESET;
            written_a        <= 1'b0;
            written_b        <= 1'b0;
            op_pending       <= 1'b0;
        end else begin
            control          <= next_control;
            operand_a        <= next_operand_a;
            operand_b        <= next_operand_b;
            accumulator_low  <= next_accumulator_low;
            accumulator_mid  <= next_accumulator_mid;
            accumulator_high <= next_accumulator_high;
            written_a        <= next_written_a;
            written_b        <= next_written_b;
            op_pending       <= next_op_pending;
        end
    end

endmodule : multiplier_operation_control

/* File: core/mult_ctrl_pkg.sv */
// Constants, register map and types of the multiplier operation control block
package mult_ctrl_pkg;

    localparam int OP_W     = 16;
    localparam int ACC_W    = 3 * OP_W;
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 32;
    localparam int IDX_W    = ADDR_W - 2;

    // Register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] MULTIPLIER_CONTROL_IDX = 10'h000;
    localparam logic [IDX_W-1:0] OPERAND_A_IDX          = 10'h001;
    localparam logic [IDX_W-1:0] OPERAND_B_IDX          = 10'h002;
    localparam logic [IDX_W-1:0] ACCUMULATOR_LOW_IDX    = 10'h004;
    localparam logic [IDX_W-1:0] ACCUMULATOR_MID_IDX    = 10'h005;
    localparam logic [IDX_W-1:0] ACCUMULATOR_HIGH_IDX   = 10'h006;
    localparam logic [IDX_W-1:0] OPERATION_STATUS_IDX   = 10'h007;

    // Control field positions
    localparam int SIGN_MODE_BIT     = 0;
    localparam int ACCUMULATE_BIT    = 1;
    localparam int SUBTRACT_BIT      = 2;
    localparam int OPERAND_COUNT_BIT = 3;
    localparam int SQUARE_BIT        = 4;

    // Status field positions
    localparam int WRITTEN_A_BIT  = 0;
    localparam int WRITTEN_B_BIT  = 1;
    localparam int PENDING_BIT    = 2;

    localparam logic [OP_W-1:0]   OPERAND_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_ZERO     = 32'h0000_0000;

    typedef struct packed {
        logic square_enable;
        logic operand_count_select;
        logic subtract_select;
        logic accumulate_select;
        logic unsigned_mode;
    } multiplier_control_t;

    localparam multiplier_control_t CONTROL_RESET = 5'h00;

    // Operation codes {subtract_select, accumulate_select}
    localparam logic [1:0] OP_PRODUCT   = 2'h0;
    localparam logic [1:0] OP_ACCUM     = 2'h1;
    localparam logic [1:0] OP_NEGATE    = 2'h2;
    localparam logic [1:0] OP_SUBTRACT  = 2'h3;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b01,
        BUS_ANSWER = 2'b10
    } bus_state_t;

endpackage : mult_ctrl_pkg

/* File: core/mac_unit.sv */
// Combinational multiply with accumulate, subtract and negate forms
`timescale 1ns/10ps
module mac_unit
    import mult_ctrl_pkg::*;
#(
    parameter int OPW  = OP_W,
    parameter int ACCW = ACC_W
) (
    input  wire logic [OPW-1:0]          operand_a,
    input  wire logic [OPW-1:0]          operand_b,
    input  wire logic [ACCW-1:0]         accumulator,
    input  wire multiplier_control_t     control,
    output logic      [ACCW-1:0]         result
);

    logic [ACCW-1:0] wide_a;
    logic [ACCW-1:0] wide_b;
    logic [ACCW-1:0] product;

    // Product kept modulo 2**ACCW, exact for signed and unsigned operands
    always_comb begin
        if (control.unsigned_mode) begin
            wide_a = {{(ACCW-OPW){1'b0}}, operand_a};
            wide_b = {{(ACCW-OPW){1'b0}}, operand_b};
        end else begin
            wide_a = {{(ACCW-OPW){operand_a[OPW-1]}}, operand_a};
            wide_b = {{(ACCW-OPW){operand_b[OPW-1]}}, operand_b};
        end
        product = ACCW'(wide_a * wide_b);
        case ({control.subtract_select, control.accumulate_select})
            OP_PRODUCT:  result = product;
            OP_ACCUM:    result = ACCW'(accumulator + product);
            OP_NEGATE:   result = ACCW'({ACCW{1'b0}} - product);
            OP_SUBTRACT: result = ACCW'(accumulator - product);
            default:     result = product;
        endcase
    end

endmodule : mac_unit

/* File: verif/multiplier_operation_control_checker.sv */
// Port-level assertions for the multiplier operation control block
`timescale 1ns/10ps
module multiplier_operation_control_checker
    import mult_ctrl_pkg::*;
(
    input wire logic              clock,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // Shadow of what software should see, rebuilt from finished writes only
    logic [4:0]  ctl, next_ctl;
    logic [1:0]  seen, next_seen;
    logic [15:0] sa, next_sa, sb, next_sb;
    logic        done_wr, rd;

    assign done_wr = psel && penable && pready && pwrite && !pslverr;
    assign rd      = psel && penable && pready && !pwrite;

    always_comb begin
        next_ctl  = ctl;
        next_seen = seen;
        next_sa   = sa;
        next_sb   = sb;
        if (done_wr && paddr == 12'h000) begin
            next_ctl = pwdata[4:0];
        end
        if (done_wr && (paddr == 12'h004 || paddr == 12'h008)) begin
            if (ctl[4] || !paddr[3]) next_sa = pwdata[15:0];
            if (ctl[4] || paddr[3]) next_sb = pwdata[15:0];
            next_seen = seen | (paddr[3] ? 2'h2 : 2'h1);
            if (ctl[4] || ctl[3] || next_seen == 2'h3) next_seen = 2'h0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctl  <= 5'h00;
            seen <= 2'h0;
            sa   <= 16'h0000;
            sb   <= 16'h0000;
        end else begin
            ctl  <= next_ctl;
            seen <= next_seen;
            sa   <= next_sa;
            sb   <= next_sb;
        end
    end

    a_ready_one_wait: assert property (psel && !penable |-> ##2 pready)
        else $error("ready not two cycles after setup");
    a_ready_single_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_idle_data_zero: assert property (!pready |-> prdata == DATA_ZERO)
        else $error("read data not zero while idle");
    a_unmapped_error: assert property (psel && penable && pready &&
        (paddr[1:0] != 2'h0 || paddr >= 12'h020 || paddr == 12'h00c) |-> pslverr)
        else $error("unmapped access without error");
    a_status_flags: assert property (rd && paddr == 12'h01c |-> prdata[1:0] == seen)
        else $error("written flags wrong");
    a_operand_b_mirror: assert property (rd && paddr == 12'h008 |-> prdata == {16'h0000, sb})
        else $error("operand b wrong");
    a_operand_a_value: assert property (rd && paddr == 12'h004 |-> prdata == {16'h0000, sa})
        else $error("operand a wrong");
    a_control_value: assert property (rd && paddr == 12'h000 |-> prdata == {27'h0, ctl})
        else $error("control readback wrong");

    cover property (done_wr && paddr == 12'h004 && ctl[4]);
    cover property (done_wr && paddr == 12'h008 && seen == 2'h1);
    cover property (rd && pslverr);
endmodule : multiplier_operation_control_checker

bind multiplier_operation_control multiplier_operation_control_checker chk (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* File: verif/multiplier_operation_control_bench.sv */
// Register-level self-checking bench for the multiplier operation control block
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module multiplier_operation_control_bench
    import mult_ctrl_pkg::*;
;
    logic        clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    int          errors = 0, checks = 0;

    always #20 clock = ~clock;

    multiplier_operation_control dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Ready, data and error are taken at the edge that completes the access
        @(posedge clock);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        if (n == 20) errors++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rd(input string n, input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(n, x, q)
    endtask : rd

    task rd_acc(input logic [47:0] x);
        rd("acc_low", 12'h010, {16'h0, x[15:0]});
        rd("acc_mid", 12'h014, {16'h0, x[31:16]});
        rd("acc_high", 12'h018, {16'h0, x[47:32]});
    endtask : rd_acc

    task rd_err(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
        `CHK("slverr", 1'b1, e)
    endtask : rd_err

    function automatic logic [47:0] mac(input logic [1:0] op, input logic us, input logic [15:0] a, b,
                                        input logic [47:0] acc);
        logic [47:0] ea, eb, p;
        ea = us ? {32'h0, a} : {{32{a[15]}}, a};
        eb = us ? {32'h0, b} : {{32{b[15]}}, b};
        p = ea * eb;
        case (op)
            2'h0: mac = p;
            2'h1: mac = acc + p;
            2'h2: mac = -p;
            default: mac = acc - p;
        endcase
    endfunction : mac

    task tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd("control", 12'h000, 32'h0);
        rd("operand_a", 12'h004, 32'h0);
        rd("status", 12'h01c, 32'h0);
        rd_acc(48'h0);
        $display("reset values done");
        for (int i = 0; i < 4; i++) begin
            wr(12'h000, {29'h0, i[1:0], 1'b0});
            wr(12'h010, 32'h1234);
            wr(12'h014, 32'h5678);
            wr(12'h018, 32'h9abc);
            wr(12'h004, 32'h8003);
            rd("status", 12'h01c, 32'h1);
            rd_acc(48'h9abc_5678_1234);
            wr(12'h008, 32'h0007);
            rd("status", 12'h01c, 32'h0);
            rd_acc(mac(i[1:0], 1'b0, 16'h8003, 16'h0007, 48'h9abc_5678_1234));
        end
        $display("operation codes done");
        wr(12'h000, 32'h09);
        wr(12'h004, 32'hffff);
        rd("status", 12'h01c, 32'h0);
        rd_acc(mac(2'h0, 1'b1, 16'hffff, 16'h0007, 48'h0));
        wr(12'h008, 32'h0002);
        rd_acc(mac(2'h0, 1'b1, 16'hffff, 16'h0002, 48'h0));
        $display("one operand done");
        wr(12'h000, 32'h10);
        wr(12'h008, 32'hfffd);
        rd("operand_a", 12'h004, 32'hfffd);
        rd_acc(48'h9);
        wr(12'h000, 32'h18);
        wr(12'h004, 32'h0005);
        rd("operand_b", 12'h008, 32'h0005);
        rd_acc(48'h19);
        wr(12'h000, 32'h08);
        wr(12'h004, 32'h0003);
        rd("operand_b", 12'h008, 32'h0005);
        rd_acc(48'hf);
        $display("square done");
        wr(12'h000, 32'h00);
        wr(12'h008, 32'h0004);
        rd("status", 12'h01c, 32'h2);
        wr(12'h008, 32'h0006);
        wr(12'h01c, 32'h7);
        `CHK("status_wr_err", 1'b0, e)
        rd("status", 12'h01c, 32'h2);
        wr(12'h00c, 32'h1f);
        `CHK("wr_slverr", 1'b1, e)
        rd("control", 12'h000, 32'h0);
        wr(12'h004, 32'hfffe);
        rd("status", 12'h01c, 32'h0);
        rd_acc(mac(2'h0, 1'b0, 16'hfffe, 16'h0006, 48'h0));
        $display("pairing done");
        wr(12'h000, 32'hffff_ffff);
        rd("control", 12'h000, 32'h1f);
        rd_err(12'h00c);
        rd_err(12'h040);
        rd_err(12'h002);
        $display("register map done");
        tally_and_finish();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        errors++;
        tally_and_finish();
    end
endmodule : multiplier_operation_control_bench
